/* drive_status_defs.vh */
// Register offsets, status bit positions, reset values and scaling constants of the drive status bank.
`ifndef DRIVE_STATUS_DEFS_VH
`define DRIVE_STATUS_DEFS_VH

// Byte offsets on the register port.
`define REG_STATUS_WORD     8'h00
`define REG_SCALED_READBACK 8'h04
`define REG_SERIAL_REF      8'h08
`define REG_FIELDBUS_REF    8'h0c
`define REG_NOM_FREQ        8'h10
`define REG_NOM_SPEED       8'h14
`define REG_REF_SELECT      8'h18
`define REG_DRIVE_CTRL      8'h1c
`define REG_RO_WRITES       8'h20

// Status word bit positions.
`define STAT_TORQUE_OFF     0
`define STAT_RUN_CMD        1
`define STAT_EMERGENCY      2
`define STAT_RESERVED3      3
`define STAT_QUICK_STOP     4
`define STAT_ALT_RAMP       5
`define STAT_CONFIG         6
`define STAT_ALARM          7
`define STAT_RUNNING        8
`define STAT_ENABLED        9
`define STAT_CLOCKWISE      10
`define STAT_INCHING        11
`define STAT_REMOTE         12
`define STAT_UNDERVOLTAGE   13
`define STAT_REG_AUTO       14
`define STAT_FAULT          15

// Drive control register field.
`define CTRL_ENABLE_REQ     0

// Reference source selection codes.
`define SEL_FIELDBUS        2'h0
`define SEL_SERIAL          2'h1
`define SEL_ANALOG          2'h2
`define SEL_PULSE           2'h3

// Reset values.
`define NOM_FREQ_RESET      16'h01f4
`define NOM_SPEED_RESET     16'h0000
`define REF_RESET           16'h0000
`define SEL_RESET           2'h0

// Speed code scaling: the unity code stands for the rated frequency.
`define SPEED_UNITY_CODE    16'h2000
`define SPEED_UNITY_SHIFT   13
`define SPEED_CODE_MAX      16'h7fff

`endif

/* ref_source_mux.v */
// Reference source selector that conditions the analog and pulse inputs and picks the ramp input code.
`timescale 1ns/1ns
`include "drive_status_defs.vh"

module ref_source_mux #(
	parameter ANALOG_W = 12
) (
	input  wire                core_clk_in,
	input  wire                rst_in,
	input  wire [1:0]          sel_in,
	input  wire [15:0]         fieldbus_code_in,
	input  wire [15:0]         serial_code_in,
	input  wire [ANALOG_W-1:0] analog_level_in,
	input  wire [15:0]         pulse_rate_in,
	output reg  [15:0]         code_out
);

	// Analog full scale lands just under the unity code, so a full input asks for rated frequency.
	wire [15:0] analog_cond;
	// The pulse count is unsigned; clamping keeps it from wrapping into a reverse reference.
	wire [15:0] pulse_cond;
	reg  [15:0] code_next;

	assign analog_cond = {{(16 - ANALOG_W - 1){1'b0}}, analog_level_in, 1'b0};
	assign pulse_cond  = pulse_rate_in[15] ? `SPEED_CODE_MAX : pulse_rate_in;

	// Pick the source that the selection names.
	always @* begin
		case (sel_in)
			`SEL_FIELDBUS: code_next = fieldbus_code_in;
			`SEL_SERIAL:   code_next = serial_code_in;
			`SEL_ANALOG:   code_next = analog_cond;
			`SEL_PULSE:    code_next = pulse_cond;
			default:       code_next = `REF_RESET;
		endcase
	end

	// One register stage toward the ramp.
	always @(posedge core_clk_in) begin
		if (rst_in) begin
			code_out <= `REF_RESET;
		end else begin
			code_out <= code_next;
		end
	end

endmodule // ref_source_mux

/* speed_code_scaler.v */
// Converter from a signed speed code to a signed frequency in the units of the rated frequency.
`timescale 1ns/1ns
`include "drive_status_defs.vh"

module speed_code_scaler (
	input  wire        core_clk_in,
	input  wire        rst_in,
	input  wire [15:0] code_in,
	input  wire [15:0] nom_freq_in,
	output reg  [19:0] freq_out
);

	wire        negative;
	wire [16:0] magnitude;
	wire [32:0] product;
	wire [19:0] quotient;
	wire [19:0] freq_next;

	// Work on the magnitude so that truncation goes toward zero in both directions.
	assign negative  = code_in[15];
	assign magnitude = negative ? (17'h00000 - {1'b1, code_in}) : {1'b0, code_in};
	// Multiply by the rated frequency, then divide by the unity code.
	assign product   = magnitude * nom_freq_in;
	assign quotient  = product[32:`SPEED_UNITY_SHIFT];
	assign freq_next = negative ? (20'h00000 - quotient) : quotient;

	// Registered result; the path above is one multiplier deep.
	always @(posedge core_clk_in) begin
		if (rst_in) begin
			freq_out <= 20'h00000;
		end else begin
			freq_out <= freq_next;
		end
	end

endmodule // speed_code_scaler

/* drive_status_bank.v */
// Drive status word and speed reference register bank with scaling of the ramp reference.
//
// Operation
// - Conditioned analog or pulse input feeds the ramp when selected.
// - Network speed reference is a signed 16-bit two's-complement value.
// - Scaling base is rated motor frequency, not rated speed.
// - Code 8192 equals rated frequency; other codes scale linearly.
// - One shared 16-bit status word, read only; writes are ignored.
// - Bit 0 set while safe torque off locks the drive.
// - Bit 1 set while any run command is active.
// - Bit 2 set while emergency override mode is active.
// - Bit 4 set while quick stop is active.
// - Bit 5 set while the alternate ramp pair is in use.
// - Bit 6 set on incompatible settings; enabling is refused meanwhile.
// - Bit 7 set while the drive is in alarm state.
// - Bit 8 set while the motor runs per reference and command.
// - Bit 9 set while the drive is fully enabled.
// - Bit 10 set while the motor spins clockwise.
// - Bit 11 set while the inching function is active.
// - Bit 12 set in remote mode, clear in local mode.
// - Bit 13 set while undervoltage exists.
// - Bit 14 set while the closed loop regulator is automatic.
// - Bit 15 set while a fault is registered.
`timescale 1ns/1ns
`include "drive_status_defs.vh"

module drive_status_bank #(
	parameter ADDR_W   = 8,
	parameter ANALOG_W = 12
) (
	input  wire                core_clk_in,
	input  wire                rst_in,

	// Register port.
	input  wire [ADDR_W-1:0]   addr_in,
	input  wire [15:0]         wr_data_in,
	input  wire                wr_strobe_in,
	input  wire                rd_strobe_in,
	output reg  [15:0]         rd_data_out,

	// Drive conditions reported in the status word.
	input  wire                safe_torque_off_in,
	input  wire                run_cmd_in,
	input  wire                emergency_mode_in,
	input  wire                quick_stop_in,
	input  wire                alt_ramp_in,
	input  wire                config_status_in,
	input  wire                alarm_in,
	input  wire                running_in,
	input  wire                clockwise_in,
	input  wire                inching_function_in,
	input  wire                remote_mode_in,
	input  wire                undervoltage_in,
	input  wire                regulator_auto_in,
	input  wire                fault_in,

	// Reference sources after their front ends.
	input  wire [ANALOG_W-1:0] analog_level_in,
	input  wire [15:0]         pulse_rate_in,

	// Results toward the rest of the drive.
	output reg  [15:0]         status_word_out,
	output reg                 drive_enable_out,
	output wire [15:0]         ramp_code_out,
	output wire [19:0]         ramp_freq_out
);

	// Software-visible registers.
	reg  [15:0] serial_ref_reg;
	reg  [15:0] serial_ref_next;
	reg  [15:0] fieldbus_ref_reg;
	reg  [15:0] fieldbus_ref_next;
	reg  [15:0] nom_freq_reg;
	reg  [15:0] nom_freq_next;
	reg  [15:0] nom_speed_reg;
	reg  [15:0] nom_speed_next;
	reg  [1:0]  ref_sel_reg;
	reg  [1:0]  ref_sel_next;
	reg         enable_req_reg;
	reg         enable_req_next;
	reg  [15:0] ro_writes_reg;
	reg  [15:0] ro_writes_next;

	// Internal state and read path.
	reg         drive_enable_next;
	reg  [15:0] status_word_next;
	reg  [15:0] rd_data_next;
	wire        wr_status;
	wire        wr_readback;
	wire        wr_ro;

	// Address compare shared by the write and the read decode.
	function hit;
		input [ADDR_W-1:0] addr;
		input [7:0]        offset;
		begin
			hit = (addr == offset[ADDR_W-1:0]);
		end
	endfunction

	// Writes aimed at the status word or the scaled readback are counted, never stored.
	assign wr_status   = wr_strobe_in & hit(addr_in, `REG_STATUS_WORD);
	assign wr_readback = wr_strobe_in & hit(addr_in, `REG_SCALED_READBACK);
	assign wr_ro       = wr_status | wr_readback;

	// Write decode for the writable registers.
	always @* begin
		serial_ref_next   = serial_ref_reg;
		fieldbus_ref_next = fieldbus_ref_reg;
		nom_freq_next     = nom_freq_reg;
		nom_speed_next    = nom_speed_reg;
		ref_sel_next      = ref_sel_reg;
		enable_req_next   = enable_req_reg;
		ro_writes_next    = ro_writes_reg;
		if (wr_strobe_in) begin
			if (hit(addr_in, `REG_SERIAL_REF)) begin
				serial_ref_next = wr_data_in;
			end
			if (hit(addr_in, `REG_FIELDBUS_REF)) begin
				fieldbus_ref_next = wr_data_in;
			end
			if (hit(addr_in, `REG_NOM_FREQ)) begin
				nom_freq_next = wr_data_in;
			end
			if (hit(addr_in, `REG_NOM_SPEED)) begin
				nom_speed_next = wr_data_in;
			end
			if (hit(addr_in, `REG_REF_SELECT)) begin
				ref_sel_next = wr_data_in[1:0];
			end
			if (hit(addr_in, `REG_DRIVE_CTRL)) begin
				enable_req_next = wr_data_in[`CTRL_ENABLE_REQ];
			end
		end
		// The counter saturates so a stuck master cannot wrap it back to zero.
		if (wr_ro && (ro_writes_reg != 16'hffff)) begin
			ro_writes_next = ro_writes_reg + 16'h0001;
		end
	end

	// The grant follows the request but is dropped and held off while settings conflict.
	always @* begin
		drive_enable_next = enable_req_reg & ~config_status_in;
	end

	// Status word assembly; every bit but reserved bit 3 and bit 9, the registered enable grant, is a plain level of the drive condition.
	always @* begin
		status_word_next                     = 16'h0000;
		status_word_next[`STAT_TORQUE_OFF]   = safe_torque_off_in;
		status_word_next[`STAT_RUN_CMD]      = run_cmd_in;
		status_word_next[`STAT_EMERGENCY]    = emergency_mode_in;
		status_word_next[`STAT_RESERVED3]    = 1'b0;
		status_word_next[`STAT_QUICK_STOP]   = quick_stop_in;
		status_word_next[`STAT_ALT_RAMP]     = alt_ramp_in;
		status_word_next[`STAT_CONFIG]       = config_status_in;
		status_word_next[`STAT_ALARM]        = alarm_in;
		status_word_next[`STAT_RUNNING]      = running_in;
		status_word_next[`STAT_ENABLED]      = drive_enable_out;
		status_word_next[`STAT_CLOCKWISE]    = clockwise_in;
		status_word_next[`STAT_INCHING]      = inching_function_in;
		status_word_next[`STAT_REMOTE]       = remote_mode_in;
		status_word_next[`STAT_UNDERVOLTAGE] = undervoltage_in;
		status_word_next[`STAT_REG_AUTO]     = regulator_auto_in;
		status_word_next[`STAT_FAULT]        = fault_in;
	end

	// Read decode; data stand only in the cycle after the strobe, unmapped reads give zero.
	always @* begin
		rd_data_next = 16'h0000;
		if (rd_strobe_in) begin
			if (hit(addr_in, `REG_STATUS_WORD)) begin
				rd_data_next = status_word_out;
			end
			if (hit(addr_in, `REG_SCALED_READBACK)) begin
				rd_data_next = ramp_code_out;
			end
			if (hit(addr_in, `REG_SERIAL_REF)) begin
				rd_data_next = serial_ref_reg;
			end
			if (hit(addr_in, `REG_FIELDBUS_REF)) begin
				rd_data_next = fieldbus_ref_reg;
			end
			if (hit(addr_in, `REG_NOM_FREQ)) begin
				rd_data_next = nom_freq_reg;
			end
			if (hit(addr_in, `REG_NOM_SPEED)) begin
				rd_data_next = nom_speed_reg;
			end
			if (hit(addr_in, `REG_REF_SELECT)) begin
				rd_data_next = {14'h0000, ref_sel_reg};
			end
			if (hit(addr_in, `REG_DRIVE_CTRL)) begin
				rd_data_next = {15'h0000, enable_req_reg};
			end
			if (hit(addr_in, `REG_RO_WRITES)) begin
				rd_data_next = ro_writes_reg;
			end
		end
	end

	// All state registers of the bank.
	always @(posedge core_clk_in) begin
		if (rst_in) begin
			serial_ref_reg   <= `REF_RESET;
			fieldbus_ref_reg <= `REF_RESET;
			nom_freq_reg     <= `NOM_FREQ_RESET;
			nom_speed_reg    <= `NOM_SPEED_RESET;
			ref_sel_reg      <= `SEL_RESET;
			enable_req_reg   <= 1'b0;
			ro_writes_reg    <= 16'h0000;
			drive_enable_out <= 1'b0;
			status_word_out  <= 16'h0000;
			rd_data_out      <= 16'h0000;
		end else begin
			serial_ref_reg   <= serial_ref_next;
			fieldbus_ref_reg <= fieldbus_ref_next;
			nom_freq_reg     <= nom_freq_next;
			nom_speed_reg    <= nom_speed_next;
			ref_sel_reg      <= ref_sel_next;
			enable_req_reg   <= enable_req_next;
			ro_writes_reg    <= ro_writes_next;
			drive_enable_out <= drive_enable_next;
			status_word_out  <= status_word_next;
			rd_data_out      <= rd_data_next;
		end
	end

	// Source selection and conditioning toward the ramp input.
	ref_source_mux #(
		.ANALOG_W         (ANALOG_W)
	) u_ref_source_mux (
		.core_clk_in      (core_clk_in),
		.rst_in           (rst_in),
		.sel_in           (ref_sel_reg),
		.fieldbus_code_in (fieldbus_ref_reg),
		.serial_code_in   (serial_ref_reg),
		.analog_level_in  (analog_level_in),
		.pulse_rate_in    (pulse_rate_in),
		.code_out         (ramp_code_out)
	);

	// The rated speed register is deliberately not wired here; only the rated frequency sets the scale.
	speed_code_scaler u_speed_code_scaler (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.code_in     (ramp_code_out),
		.nom_freq_in (nom_freq_reg),
		.freq_out    (ramp_freq_out)
	);

endmodule // drive_status_bank

/* drive_status_bank_asserts.sv */
// Checker of the port relations of the drive status bank.
`timescale 1ns/1ns
`include "drive_status_defs.vh"

module drive_status_bank_asserts #(
	parameter ADDR_W = 8
) (
	input wire              core_clk_in,
	input wire              rst_in,
	input wire [ADDR_W-1:0] addr_in,
	input wire              rd_strobe_in,
	input wire [15:0]       rd_data_out,
	input wire              safe_torque_off_in,
	input wire              run_cmd_in,
	input wire              emergency_mode_in,
	input wire              quick_stop_in,
	input wire              alt_ramp_in,
	input wire              config_status_in,
	input wire              alarm_in,
	input wire              running_in,
	input wire              clockwise_in,
	input wire              inching_function_in,
	input wire              remote_mode_in,
	input wire              undervoltage_in,
	input wire              regulator_auto_in,
	input wire              fault_in,
	input wire [15:0]       status_word_out,
	input wire              drive_enable_out,
	input wire [15:0]       ramp_code_out,
	input wire [19:0]       ramp_freq_out
);
	// Conditions gathered in status order, leaving out bits 3 and 9.
	wire [13:0] cond_vec;
	assign cond_vec = {fault_in, regulator_auto_in, undervoltage_in, remote_mode_in, inching_function_in,
		clockwise_in, running_in, alarm_in, config_status_in, alt_ramp_in, quick_stop_in,
		emergency_mode_in, run_cmd_in, safe_torque_off_in};

	// All relations share the core clock; reset voids them.
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	a_status_low: assert property (!$past(rst_in) |->
		{status_word_out[8:4], status_word_out[2:0]} == $past(cond_vec[7:0])) else $error("low status bit wrong");
	a_status_bits: assert property (!$past(rst_in) |->
		status_word_out[15:10] == $past(cond_vec[13:8])) else $error("status bit does not follow its condition");
	a_reserved_zero: assert property (status_word_out[`STAT_RESERVED3] == 1'b0) else $error("reserved bit set");
	a_alarm_hold: assert property (alarm_in [*3] |=> status_word_out[`STAT_ALARM]) else $error("alarm bit lost");
	a_enable_refused: assert property (config_status_in |=> !drive_enable_out) else $error("enabled in config");
	a_enabled_bit: assert property (!$past(rst_in) |-> status_word_out[`STAT_ENABLED] == $past(drive_enable_out))
		else $error("enabled bit mismatch");
	a_status_read: assert property (rd_strobe_in && addr_in == `REG_STATUS_WORD |=>
		rd_data_out == $past(status_word_out)) else $error("status read mismatch");
	a_readback_read: assert property (rd_strobe_in && addr_in == `REG_SCALED_READBACK |=>
		rd_data_out == $past(ramp_code_out)) else $error("readback mismatch");
	a_freq_sign: assert property ($signed(ramp_code_out) < 0 |=> $signed(ramp_freq_out) <= 0)
		else $error("frequency sign lost");
	a_freq_zero: assert property (ramp_code_out == 16'h0000 |=> ramp_freq_out == 20'h00000)
		else $error("zero code gives nonzero frequency");
endmodule // drive_status_bank_asserts

/* host_port.sv */
// Register port master standing for the network module or external controller.
`timescale 1ns/1ns

module host_port (
	input  wire        core_clk_in,
	input  wire [15:0] rd_data_in,
	output reg  [7:0]  addr_out,
	output reg  [15:0] wr_data_out,
	output reg         wr_strobe_out,
	output reg         rd_strobe_out
);
	// Idle bus from time zero, so nothing is requested during reset.
	initial begin
		addr_out = 8'h00;
		wr_data_out = 16'h0000;
		wr_strobe_out = 1'b0;
		rd_strobe_out = 1'b0;
	end

	// One write cycle; the bus is scrambled on release so stale values never pass.
	task wr_reg(input [7:0] a, input [15:0] d);
		begin
			@(posedge core_clk_in);
			addr_out <= a;
			wr_data_out <= d;
			wr_strobe_out <= 1'b1;
			@(posedge core_clk_in);
			wr_strobe_out <= 1'b0;
			addr_out <= ~a;
			wr_data_out <= ~d;
		end
	endtask

	// One read cycle; data stand only in the cycle after the strobe.
	task rd_reg(input [7:0] a, output [15:0] d);
		begin
			@(posedge core_clk_in);
			addr_out <= a;
			rd_strobe_out <= 1'b1;
			@(posedge core_clk_in);
			rd_strobe_out <= 1'b0;
			addr_out <= ~a;
			#1;
			d = rd_data_in;
		end
	endtask
endmodule // host_port

/* tb_top.sv */
// Self-checking bench of the drive status bank.
`timescale 1ns/1ns
`include "drive_status_defs.vh"

module tb_top;
	reg         core_clk_in;
	reg         rst_in;
	reg  [15:0] cond;
	reg  [11:0] analog_level;
	reg  [15:0] pulse_rate;
	wire [7:0]  addr;
	wire [15:0] wr_data;
	wire        wr_strobe;
	wire        rd_strobe;
	wire [15:0] rd_data;
	wire [15:0] status_word;
	wire        drive_enable;
	wire [15:0] ramp_code;
	wire [19:0] ramp_freq;
	reg  [15:0] rd;
	reg  [15:0] codes [0:5];
	integer     err_count;
	integer     tests_run;
	integer     i;
	integer     n;

	drive_status_bank i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wr_data),
		.wr_strobe_in(wr_strobe), .rd_strobe_in(rd_strobe), .rd_data_out(rd_data),
		.safe_torque_off_in(cond[0]), .run_cmd_in(cond[1]), .emergency_mode_in(cond[2]), .quick_stop_in(cond[4]),
		.alt_ramp_in(cond[5]), .config_status_in(cond[6]), .alarm_in(cond[7]), .running_in(cond[8]),
		.clockwise_in(cond[10]), .inching_function_in(cond[11]), .remote_mode_in(cond[12]),
		.undervoltage_in(cond[13]), .regulator_auto_in(cond[14]), .fault_in(cond[15]),
		.analog_level_in(analog_level), .pulse_rate_in(pulse_rate), .status_word_out(status_word),
		.drive_enable_out(drive_enable), .ramp_code_out(ramp_code), .ramp_freq_out(ramp_freq));

	host_port i_host (.core_clk_in(core_clk_in), .rd_data_in(rd_data), .addr_out(addr), .wr_data_out(wr_data),
		.wr_strobe_out(wr_strobe), .rd_strobe_out(rd_strobe));

	// Magnitude is scaled and the sign put back, so truncation goes toward zero.
	function [19:0] exp_freq(input [15:0] c, input [15:0] nf);
		reg [16:0] mag;
		reg [32:0] p;
		begin
			mag = c[15] ? (17'h10000 - {1'b0, c}) : {1'b0, c};
			p = (mag * nf) >> 13;
			exp_freq = c[15] ? (20'h00000 - p[19:0]) : p[19:0];
		end
	endfunction

	task chk(input [19:0] got, input [19:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask

	task rd_chk(input [7:0] a, input [15:0] e);
		begin
			i_host.rd_reg(a, rd);
			chk({4'h0, rd}, {4'h0, e});
		end
	endtask

	task end_of_test;
		begin
			$display("checks %0d, mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask

	// Free-running 100 MHz core clock.
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	// Whole sequence needs a few hundred cycles; this limit only catches a hang.
	initial begin
		#200000;
		err_count = err_count + 1;
		end_of_test;
	end

	// Main sequence of register port transfers and checks.
	initial begin
		err_count = 0;
		tests_run = 0;
		rst_in = 1'b1;
		cond = 16'h0000;
		analog_level = 12'h000;
		pulse_rate = 16'h0000;
		codes[0] = 16'h2000;
		codes[1] = 16'h7fff;
		codes[2] = 16'h8000;
		codes[3] = 16'he000;
		codes[4] = 16'h0001;
		codes[5] = 16'hffff;
		repeat (5) @(posedge core_clk_in);
		rst_in <= 1'b0;
		rd_chk(`REG_NOM_FREQ, 16'h01f4);
		rd_chk(`REG_STATUS_WORD, 16'h0000);
		for (i = 0; i < 16; i = i + 1) begin
			if (i != 3 && i != 9) begin
				@(posedge core_clk_in) cond <= 16'h0001 << i;
				repeat (2) @(posedge core_clk_in);
				if (i < 8) begin
					rd_chk(`REG_STATUS_WORD, 16'h0001 << i);
				end else begin
					rd_chk(`REG_STATUS_WORD, 16'h0001 << i);
				end
			end
		end
		@(posedge core_clk_in) cond <= 16'h0000;
		i_host.wr_reg(`REG_STATUS_WORD, 16'hffff);
		i_host.wr_reg(`REG_SCALED_READBACK, 16'hffff);
		rd_chk(`REG_STATUS_WORD, 16'h0000);
		rd_chk(`REG_RO_WRITES, 16'h0002);
		rd_chk(8'h3c, 16'h0000);
		i_host.wr_reg(`REG_DRIVE_CTRL, 16'h0001);
		repeat (3) @(posedge core_clk_in);
		rd_chk(`REG_STATUS_WORD, 16'h0200);
		@(posedge core_clk_in) cond <= 16'h0040;
		repeat (3) @(posedge core_clk_in);
		chk({19'h00000, drive_enable}, 20'h00000);
		rd_chk(`REG_STATUS_WORD, 16'h0040);
		@(posedge core_clk_in) cond <= 16'h0000;
		repeat (3) @(posedge core_clk_in);
		rd_chk(`REG_STATUS_WORD, 16'h0200);
		// Two rated frequencies; the rated speed written between must not matter.
		for (n = 0; n < 2; n = n + 1) begin
			i_host.wr_reg(`REG_NOM_FREQ, n ? 16'h0064 : 16'h01f4);
			i_host.wr_reg(`REG_NOM_SPEED, 16'h1234);
			for (i = 0; i < 6; i = i + 1) begin
				i_host.wr_reg(`REG_FIELDBUS_REF, codes[i]);
				repeat (4) @(posedge core_clk_in);
				chk(ramp_freq, exp_freq(codes[i], n ? 16'h0064 : 16'h01f4));
				rd_chk(`REG_SCALED_READBACK, codes[i]);
			end
		end
		// Literal end point at rated frequency 100: the most negative code is four times rated, reversed.
		i_host.wr_reg(`REG_FIELDBUS_REF, 16'h8000);
		repeat (4) @(posedge core_clk_in);
		chk(ramp_freq, 20'hffe70);
		i_host.wr_reg(`REG_SERIAL_REF, 16'hc000);
		i_host.wr_reg(`REG_REF_SELECT, {14'h0000, `SEL_SERIAL});
		repeat (3) @(posedge core_clk_in);
		chk({4'h0, ramp_code}, 20'h0c000);
		analog_level <= 12'hfff;
		i_host.wr_reg(`REG_REF_SELECT, {14'h0000, `SEL_ANALOG});
		repeat (3) @(posedge core_clk_in);
		chk({4'h0, ramp_code}, 20'h01ffe);
		pulse_rate <= 16'h9000;
		i_host.wr_reg(`REG_REF_SELECT, {14'h0000, `SEL_PULSE});
		repeat (3) @(posedge core_clk_in);
		chk({4'h0, ramp_code}, 20'h07fff);
		@(posedge core_clk_in) pulse_rate <= 16'h1234;
		repeat (3) @(posedge core_clk_in);
		chk({4'h0, ramp_code}, 20'h01234);
		// A reset in mid-run must bring the outputs, the rated frequency, the write counter and the status word back to their reset values.
		@(posedge core_clk_in) rst_in <= 1'b1;
		repeat (5) @(posedge core_clk_in);
		rst_in <= 1'b0;
		chk({19'h00000, drive_enable}, 20'h00000);
		chk({4'h0, ramp_code}, 20'h00000);
		chk(ramp_freq, 20'h00000);
		rd_chk(`REG_NOM_FREQ, 16'h01f4);
		rd_chk(`REG_RO_WRITES, 16'h0000);
		rd_chk(`REG_STATUS_WORD, 16'h0000);
		end_of_test;
	end
endmodule // tb_top

bind drive_status_bank drive_status_bank_asserts #(.ADDR_W(ADDR_W)) i_chk (.core_clk_in(core_clk_in),
	.rst_in(rst_in), .addr_in(addr_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
	.safe_torque_off_in(safe_torque_off_in), .run_cmd_in(run_cmd_in), .emergency_mode_in(emergency_mode_in),
	.quick_stop_in(quick_stop_in), .alt_ramp_in(alt_ramp_in), .config_status_in(config_status_in),
	.alarm_in(alarm_in), .running_in(running_in), .clockwise_in(clockwise_in),
	.inching_function_in(inching_function_in), .remote_mode_in(remote_mode_in),
	.undervoltage_in(undervoltage_in), .regulator_auto_in(regulator_auto_in), .fault_in(fault_in),
	.status_word_out(status_word_out), .drive_enable_out(drive_enable_out), .ramp_code_out(ramp_code_out),
	.ramp_freq_out(ramp_freq_out));
